// ---- common/ebct_pkg.sv ----
// Purpose: Shared constants and types of the eight-bit compare timer
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Offsets are byte addresses on the APB side

package ebct_pkg;

  localparam int ADDR_W = 8;
  localparam int CNT_W = 8;
  localparam int PRESC_W = 6;

  typedef logic [ADDR_W-1:0] ebct_addr_t;
  typedef logic [31:0] ebct_word_t;
  typedef logic [CNT_W-1:0] ebct_cnt_t;

  // Register byte offsets
  localparam ebct_addr_t OFS_COUNT = 8'h00;
  localparam ebct_addr_t OFS_MATCH_A = 8'h04;
  localparam ebct_addr_t OFS_MATCH_B = 8'h08;
  localparam ebct_addr_t OFS_CTRL_ZERO = 8'h0c;
  localparam ebct_addr_t OFS_OUT_CTRL = 8'h10;
  localparam ebct_addr_t OFS_CTRL_ONE = 8'h14;
  localparam ebct_addr_t OFS_IRQ_STATUS = 8'h18;
  localparam ebct_addr_t OFS_IRQ_MASK = 8'h1c;

  // Reset values and count limit
  localparam ebct_cnt_t COUNT_RST = 8'h00;
  localparam ebct_cnt_t MATCH_RST = 8'hff;
  localparam ebct_cnt_t COUNT_MAX = 8'hff;

  // Field positions within the write word
  localparam int CTRL0_CKS_LSB = 0;
  localparam int CTRL0_CLR_LSB = 3;
  localparam int CTRL1_EXT_BIT = 0;
  localparam int CTRL1_TRIGGER_START_ENABLE_BIT = 2;
  localparam int CTRL1_EDGE_LSB = 3;
  localparam int OSEL_A_LSB = 0;
  localparam int OSEL_B_LSB = 2;

  // Reserved bits of timer_ctrl_one
  localparam logic [2:0] CTRL1_RSVD_HI = 3'h7;
  localparam logic CTRL1_RSVD_LO = 1'b1;

  // Trigger edge codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Output action codes, ordered by priority
  localparam logic [1:0] OUT_KEEP = 2'h0;
  localparam logic [1:0] OUT_LOW = 2'h1;
  localparam logic [1:0] OUT_HIGH = 2'h2;
  localparam logic [1:0] OUT_TOGGLE = 2'h3;

  // Counter clear sources
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_MATCH_A = 2'h1;
  localparam logic [1:0] CLR_MATCH_B = 2'h2;
  localparam logic [1:0] CLR_PIN = 2'h3;

  // Clock select: 0 stops, 1..3 with the ext bit give six dividers
  localparam logic [2:0] CKS_STOP = 3'h0;
  localparam logic [2:0] CKS_LAST = 3'h3;

  typedef struct packed {
    logic [1:0] clear_sel;
    logic [2:0] clock_select;
  } ebct_ctrl0_t;

  typedef struct packed {
    logic [1:0] trig_edge;
    logic trigger_start_enable;
    logic clock_select_ext_bit;
  } ebct_ctrl1_t;

  typedef struct packed {
    logic [1:0] out_sel_b;
    logic [1:0] out_sel_a;
  } ebct_osel_t;

  typedef struct packed {
    logic match_b_flag;
    logic match_a_flag;
    logic rollover_flag;
  } ebct_evt_t;

  typedef enum logic {cnt_run, cnt_halt} ebct_run_t;

endpackage

// ---- verilog/ebct_timer.sv ----
// Purpose: Eight-bit up-counter with two compare matches and APB registers
// Assumes: Single pclk domain, pins synchronised inside
// Notes: No wait state on any APB access; pready is high in the first access cycle
//
// The address map and the APB register port were left to the implementer.

`timescale 1ns/100ps

// Behaviour
// - Each match drives output: low, high, toggle
// - Code zero leaves output unchanged on match
// - Output low after reset until first match
// - Control one reserved bits read as ones
// - Edge field selects none, rise, fall, both
// - Trigger enable starts on edge, halts on clear
// - Ext bit plus clock select choose clock
// - Six divider sources; counts once source chosen
// - Rollover sets flag, interrupt when enabled
// - Counter compared at each count tick, sets match flags
// - Match signalled in last equal state
// - Match interrupt when its enable is set
// - Clear select one or two clears on match
// - Code three clears on clear pin rise
// - Trigger mode halts after clear until edge
// - Clear beats counter write; write beats increment
// - Toggle beats high, high beats low
module ebct_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire ebct_pkg::ebct_addr_t paddr,
  input wire ebct_pkg::ebct_word_t pwdata,
  output ebct_pkg::ebct_word_t prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic trigger_pin,
  input wire logic clear_pin,
  output logic wave_out_pin,
  // Interrupt
  output logic irq
);
  import ebct_pkg::*;

  function automatic logic [1:0] act_max(input logic [1:0] a,
                                         input logic [1:0] b);
    act_max = (a > b) ? a : b;
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic now, input logic prev);
    logic rise;
    logic fall;
    rise = now & ~prev;
    fall = ~now & prev;
    case (sel)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic mapped(input ebct_addr_t a);
    case (a)
      OFS_COUNT, OFS_MATCH_A, OFS_MATCH_B, OFS_CTRL_ZERO,
      OFS_OUT_CTRL, OFS_CTRL_ONE, OFS_IRQ_STATUS, OFS_IRQ_MASK:
        mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // State
  ebct_cnt_t count_r, count_nxt;
  ebct_cnt_t match_a_r, match_a_nxt;
  ebct_cnt_t match_b_r, match_b_nxt;
  ebct_ctrl0_t ctrl0_r, ctrl0_nxt;
  ebct_ctrl1_t ctrl1_r, ctrl1_nxt;
  ebct_osel_t osel_r, osel_nxt;
  ebct_evt_t status_r, status_nxt;
  ebct_evt_t mask_r, mask_nxt;
  ebct_run_t run_r, run_nxt;
  logic [PRESC_W-1:0] presc_r, presc_nxt;
  logic tap_prev_r, tap_prev_nxt;
  logic [2:0] trig_sync_r, trig_sync_nxt;
  logic [2:0] clr_sync_r, clr_sync_nxt;
  logic wave_r, wave_nxt;
  logic irq_r, irq_nxt;
  ebct_word_t prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;

  // Decoded strobes
  logic setup, wr_acc, rd_acc;
  logic wr_count, wr_match_a, wr_match_b;
  logic [2:0] tap_idx;
  logic src_on, tap_now, tick, count_tick;
  logic hit_a, hit_b, clr_rise, trig_edge_seen, clr_evt, roll;
  logic [1:0] act;
  ebct_evt_t ev_set, ev_clr;

  always_comb begin
    setup = psel & ~penable;
    wr_acc = psel & penable & pready_r & pwrite;
    rd_acc = psel & penable & pready_r & ~pwrite;
    wr_count = wr_acc && (paddr == OFS_COUNT);
    wr_match_a = wr_acc && (paddr == OFS_MATCH_A);
    wr_match_b = wr_acc && (paddr == OFS_MATCH_B);
  end

  // Pin synchronisers; third stage only for edge detection
  always_comb begin
    trig_sync_nxt = {trig_sync_r[1:0], trigger_pin};
    clr_sync_nxt = {clr_sync_r[1:0], clear_pin};
    clr_rise = clr_sync_r[1] & ~clr_sync_r[2];
    trig_edge_seen = edge_hit(ctrl1_r.trig_edge, trig_sync_r[1],
                              trig_sync_r[2]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_sync_r <= 3'h0;
      clr_sync_r <= 3'h0;
    end else begin
      trig_sync_r <= trig_sync_nxt;
      clr_sync_r <= clr_sync_nxt;
    end
  end

  // Prescaler and counter clock selection
  always_comb begin
    presc_nxt = presc_r + {{(PRESC_W-1){1'b0}}, 1'b1};
    src_on = (ctrl0_r.clock_select != CKS_STOP) &&
             (ctrl0_r.clock_select <= CKS_LAST);
    tap_idx = 3'(((ctrl0_r.clock_select - 3'h1) << 1) |
                 {2'h0, ctrl1_r.clock_select_ext_bit});
    tap_now = src_on ? presc_r[tap_idx] : 1'b0;
    tap_prev_nxt = tap_now;
    // Increment on falling edge of the selected divider
    tick = src_on & tap_prev_r & ~tap_now;
    count_tick = tick && (run_r == cnt_run);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= '0;
      tap_prev_r <= 1'b0;
    end else begin
      presc_r <= presc_nxt;
      tap_prev_r <= tap_prev_nxt;
    end
  end

  // Compare, clear and rollover
  always_comb begin
    // Match seen in the last equal state, just before the count moves
    hit_a = count_tick && (count_r == match_a_r) && !wr_match_a;
    hit_b = count_tick && (count_r == match_b_r) && !wr_match_b;
    case (ctrl0_r.clear_sel)
      CLR_MATCH_A: clr_evt = hit_a;
      CLR_MATCH_B: clr_evt = hit_b;
      CLR_PIN: clr_evt = clr_rise;
      default: clr_evt = 1'b0;
    endcase
    roll = count_tick && (count_r == COUNT_MAX) && !clr_evt && !wr_count;
    if (clr_evt) begin
      count_nxt = COUNT_RST;
    end else if (wr_count) begin
      count_nxt = pwdata[CNT_W-1:0];
    end else if (count_tick) begin
      count_nxt = count_r + 8'h01;
    end else begin
      count_nxt = count_r;
    end
  end

  // Trigger start and halt
  always_comb begin
    run_nxt = run_r;
    if (!ctrl1_r.trigger_start_enable) begin
      run_nxt = cnt_run;
    end else if (trig_edge_seen) begin
      run_nxt = cnt_run;
    end else if (clr_evt) begin
      run_nxt = cnt_halt;
    end
  end

  // Waveform output
  always_comb begin
    act = act_max(hit_a ? osel_r.out_sel_a : OUT_KEEP,
                  hit_b ? osel_r.out_sel_b : OUT_KEEP);
    case (act)
      OUT_LOW: wave_nxt = 1'b0;
      OUT_HIGH: wave_nxt = 1'b1;
      OUT_TOGGLE: wave_nxt = ~wave_r;
      default: wave_nxt = wave_r;
    endcase
  end

  // Register writes
  always_comb begin
    match_a_nxt = wr_match_a ? pwdata[CNT_W-1:0] : match_a_r;
    match_b_nxt = wr_match_b ? pwdata[CNT_W-1:0] : match_b_r;
    ctrl0_nxt = ctrl0_r;
    ctrl1_nxt = ctrl1_r;
    osel_nxt = osel_r;
    mask_nxt = mask_r;
    if (wr_acc && (paddr == OFS_CTRL_ZERO)) begin
      ctrl0_nxt.clock_select = pwdata[CTRL0_CKS_LSB +: 3];
      ctrl0_nxt.clear_sel = pwdata[CTRL0_CLR_LSB +: 2];
    end
    if (wr_acc && (paddr == OFS_CTRL_ONE)) begin
      ctrl1_nxt.clock_select_ext_bit = pwdata[CTRL1_EXT_BIT];
      ctrl1_nxt.trigger_start_enable = pwdata[CTRL1_TRIGGER_START_ENABLE_BIT];
      ctrl1_nxt.trig_edge = pwdata[CTRL1_EDGE_LSB +: 2];
    end
    if (wr_acc && (paddr == OFS_OUT_CTRL)) begin
      osel_nxt.out_sel_a = pwdata[OSEL_A_LSB +: 2];
      osel_nxt.out_sel_b = pwdata[OSEL_B_LSB +: 2];
    end
    if (wr_acc && (paddr == OFS_IRQ_MASK)) begin
      mask_nxt = pwdata[2:0];
    end
  end

  // Sticky flags; read clears only bits reported, set wins
  always_comb begin
    ev_set.rollover_flag = roll;
    ev_set.match_a_flag = hit_a;
    ev_set.match_b_flag = hit_b;
    ev_clr = (rd_acc && (paddr == OFS_IRQ_STATUS)) ? prdata_r[2:0] : '0;
    status_nxt = (status_r & ~ev_clr) | ev_set;
    irq_nxt = |(status_nxt & mask_nxt);
  end

  // APB read data, captured in setup, answered one cycle later
  always_comb begin
    prdata_nxt = prdata_r;
    pready_nxt = setup;
    pslverr_nxt = setup & ~mapped(paddr);
    if (setup && !pwrite) begin
      case (paddr)
        OFS_COUNT: prdata_nxt = {24'h000000, count_r};
        OFS_MATCH_A: prdata_nxt = {24'h000000, match_a_r};
        OFS_MATCH_B: prdata_nxt = {24'h000000, match_b_r};
        OFS_CTRL_ZERO: prdata_nxt = {27'h0000000, ctrl0_r};
        OFS_OUT_CTRL: prdata_nxt = {28'h0000000, osel_r};
        OFS_CTRL_ONE: prdata_nxt = {24'h000000, CTRL1_RSVD_HI,
                                    ctrl1_r.trig_edge,
                                    ctrl1_r.trigger_start_enable,
                                    CTRL1_RSVD_LO,
                                    ctrl1_r.clock_select_ext_bit};
        OFS_IRQ_STATUS: prdata_nxt = {29'h00000000, status_r};
        OFS_IRQ_MASK: prdata_nxt = {29'h00000000, mask_r};
        default: prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= COUNT_RST;
      match_a_r <= MATCH_RST;
      match_b_r <= MATCH_RST;
      ctrl0_r <= '0;
      ctrl1_r <= '0;
      osel_r <= '0;
      status_r <= '0;
      mask_r <= '0;
      run_r <= cnt_run;
      wave_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      match_a_r <= match_a_nxt;
      match_b_r <= match_b_nxt;
      ctrl0_r <= ctrl0_nxt;
      ctrl1_r <= ctrl1_nxt;
      osel_r <= osel_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      run_r <= run_nxt;
      wave_r <= wave_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign wave_out_pin = wave_r;
  assign irq = irq_r;

endmodule

// ---- test/ebct_props.sv ----
// Purpose: Concurrent checks on the timer's APB and interrupt ports
// Assumes: No wait state on any access, registered outputs
// Notes: Attached by bind at the foot of this file
`timescale 1ns/100ps
module ebct_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire ebct_pkg::ebct_addr_t paddr,
  input wire ebct_pkg::ebct_word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt
  input wire logic irq
);
  import ebct_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_wait: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_err_map: assert property (pready |->
    pslverr == (paddr[1:0] != 2'h0 || paddr > OFS_IRQ_MASK))
    else $error("wrong decode");
  chk_err_zero: assert property (pready && pslverr && !pwrite |->
    prdata == 32'h0) else $error("refused read not zero");
  chk_ctrl1_ones: assert property (pready && !pwrite && !pslverr &&
    paddr == OFS_CTRL_ONE |-> prdata[7:5] == CTRL1_RSVD_HI && prdata[1])
    else $error("reserved bits not one");
  chk_rdata_hold: assert property ($changed(prdata) |->
    $past(psel && !penable && !pwrite)) else $error("read data moved");
  chk_irq_fall: assert property ($fell(irq) |-> $past(pready &&
    (!pwrite && paddr == OFS_IRQ_STATUS || pwrite && paddr == OFS_IRQ_MASK)))
    else $error("irq dropped without cause");
endmodule
bind ebct_timer ebct_props chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// ---- test/ebct_pins.sv ----
// Purpose: Far-side model driving the trigger and clear pins
// Assumes: Calls start just after a rising pclk edge
// Notes: Pins idle low
`timescale 1ns/100ps
module ebct_pins (
  // Clock
  input wire logic pclk,
  // Pins toward the timer
  output logic trigger_pin,
  output logic clear_pin
);
  initial begin
    trigger_pin = 1'b0;
    clear_pin = 1'b0;
  end
  task automatic set_trig(input logic v);
    trigger_pin <= v;
    @(posedge pclk);
  endtask
  task automatic clear_pulse();
    clear_pin <= 1'b1;
    repeat (2) @(posedge pclk);
    clear_pin <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// ---- test/testbench.sv ----
// Purpose: Self-checking bench for the eight-bit compare timer
// Assumes: APB master waits for pready, pins from ebct_pins
// Notes: Count checks allow for prescaler phase
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("FAIL %0t got %h want %h", $time, a, b); end end
module testbench;
  import ebct_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  ebct_addr_t paddr = '0;
  ebct_word_t pwdata = '0;
  ebct_word_t prdata;
  ebct_word_t rd_w;
  logic pready, pslverr, trigger_pin, clear_pin, wave_out_pin, irq, err_b;
  int failures = 0;
  int check_count = 0;
  int k;
  int e;
  logic [3:0] osel [6] = '{4'h9, 4'h0, 4'h5, 4'h6, 4'hd, 4'h7};
  logic [5:0] wexp = 6'b101011;
  always #50 pclk = ~pclk;
  ebct_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_pin(trigger_pin), .clear_pin(clear_pin),
    .wave_out_pin(wave_out_pin), .irq(irq));
  ebct_pins pins_u (.pclk(pclk), .trigger_pin(trigger_pin),
    .clear_pin(clear_pin));
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input ebct_addr_t a, input ebct_word_t d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      $display("FAIL %0t no ready", $time);
      end_of_test();
    end
    // Taken at the edge where ready is high, then released
    rd_w = prdata;
    err_b = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 3000) begin
      failures++;
      $display("FAIL %0t no interrupt", $time);
      end_of_test();
    end
    @(posedge pclk);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, OFS_CTRL_ONE, 0);
    `CHK(rd_w, 32'he2)
    xfer(1, OFS_CTRL_ONE, 32'hff);
    xfer(0, OFS_CTRL_ONE, 0);
    `CHK(rd_w, 32'hff)
    xfer(1, OFS_CTRL_ONE, 0);
    xfer(0, 8'h20, 0);
    `CHK({err_b, rd_w}, 33'h100000000)
    xfer(1, OFS_MATCH_A, 3);
    xfer(1, OFS_MATCH_B, 3);
    xfer(1, OFS_IRQ_MASK, 2);
    @(negedge pclk);
    `CHK(wave_out_pin, 1'b0)
    // A and B match together; A clears on even, B on odd passes
    for (k = 0; k < 6; k++) begin
      xfer(1, OFS_OUT_CTRL, osel[k]);
      xfer(1, OFS_COUNT, 0);
      xfer(1, OFS_CTRL_ZERO, (k % 2) ? 32'h11 : 32'h09);
      wait_irq();
      xfer(1, OFS_CTRL_ZERO, 32'h08);
      xfer(0, OFS_IRQ_STATUS, 0);
      `CHK(rd_w, 32'h6)
      @(negedge pclk);
      `CHK(wave_out_pin, wexp[k])
      `CHK(irq, 1'b0)
      // Cleared at the match, so only a few counts since
      xfer(0, OFS_COUNT, 0);
      `CHK(rd_w < 4, 1'b1)
    end
    xfer(1, OFS_IRQ_MASK, 1);
    xfer(1, OFS_COUNT, 32'hfe);
    xfer(1, OFS_CTRL_ZERO, 1);
    wait_irq();
    xfer(1, OFS_CTRL_ZERO, 0);
    xfer(0, OFS_IRQ_STATUS, 0);
    `CHK(rd_w[0], 1'b1)
    // Six dividers, roughly 259 pclk of counting
    for (k = 0; k < 6; k++) begin
      xfer(1, OFS_CTRL_ONE, k % 2);
      xfer(1, OFS_COUNT, 0);
      xfer(1, OFS_CTRL_ZERO, k / 2 + 1);
      repeat (256) @(posedge pclk);
      xfer(1, OFS_CTRL_ZERO, 0);
      xfer(0, OFS_COUNT, 0);
      e = 128 >> k;
      `CHK(rd_w + 2 >= e && rd_w <= e + 3, 1'b1)
    end
    xfer(1, OFS_CTRL_ZERO, 32'h19);
    for (k = 0; k < 4; k++) begin
      pins_u.set_trig(k == 2);
      xfer(1, OFS_CTRL_ONE, k * 8 + 4);
      pins_u.clear_pulse();
      repeat (20) @(posedge pclk);
      xfer(0, OFS_COUNT, 0);
      `CHK(rd_w, 32'h0)
      pins_u.set_trig(k != 2);
      repeat (20) @(posedge pclk);
      xfer(0, OFS_COUNT, 0);
      `CHK(rd_w != 0, k != 0)
    end
    end_of_test();
  end
endmodule
